// [x86_decode_latency_classifier_bench.sv]
`timescale 1ns/100ps
module x86_decode_latency_classifier_bench;
	logic        clk;
	logic        rst;
	logic [2:0]  in_valid, in_size32;
	logic [23:0] in_opcode, in_modrm;
	logic [14:0] in_nest;
	logic [2:0]  o_valid, o_unc, o_micro, o_latv, o_sp, o_mem, o_dest, o_nop, o_exec;
	logic [23:0] o_lat, o_hi, o_splat;
	logic [8:0]  o_mid, o_low;
	int          failures;
	int          n_tests;
	// ----
	// clock, partner and design
	// ----
	initial clk = 1'b0;
	always #5 clk = ~clk;
	xdlc_fetch_model xdlc_fetch_model_inst (.clk(clk), .valid(in_valid), .opcode(in_opcode),
		.modrm(in_modrm), .size32(in_size32), .nest(in_nest));
	xdlc_top xdlc_top_inst (.CLK(clk), .RST(rst), .IN_VALID(in_valid), .IN_OPCODE(in_opcode),
		.IN_MODRM(in_modrm), .IN_OPSIZE32(in_size32), .IN_NEST(in_nest), .OUT_VALID(o_valid),
		.OUT_UNCLASS(o_unc), .OUT_MICRO(o_micro), .OUT_LAT_VALID(o_latv), .OUT_LATENCY(o_lat),
		.OUT_HI_LATENCY(o_hi), .OUT_SP_UPDATE(o_sp), .OUT_SP_LATENCY(o_splat),
		.OUT_MEM_FORM(o_mem), .OUT_MID_REG(o_mid), .OUT_LOW_REG(o_low), .OUT_DEST_MID(o_dest),
		.OUT_NOP(o_nop), .OUT_EXEC_USE(o_exec));
	// ----
	// shared helpers
	// ----
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] want);
		n_tests++;
		if (got !== want) begin
			failures++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
		end
	endtask
	// one-cycle answer: look just after the edge that samples the request
	task automatic step(input logic [2:0] v, input logic [23:0] op, input logic [23:0] mr,
		input logic [2:0] sz, input logic [14:0] n);
		xdlc_fetch_model_inst.send(v, op, mr, sz, n);
		@(posedge clk);
		#1;
	endtask
	// micro, unclass, mem form and latency of one slot
	function automatic logic [15:0] cls(input int s);
		return {5'h00, o_micro[s], o_unc[s], o_mem[s], o_lat[8*s +: 8]};
	endfunction
	task automatic t_ascii();
		logic [7:0] ops [4] = '{8'h37, 8'hD5, 8'hD4, 8'h3F};
		for (int k = 0; k < 4; k++) begin
			step(3'h1, {16'h0000, ops[k]}, 24'h00_0000, 3'h0, 15'h0000);
			chk("ascii", cls(0), ops[k] == 8'hD4 ? 16'h0410 : 16'h0406);
		end
	endtask
	// add and carry-add, every mod value, accumulator forms ignore the mod and middle fields of the modrm byte
	task automatic t_alu();
		logic [7:0]  op;
		logic [15:0] rg;
		for (int b = 0; b < 2; b++) begin
			for (int i = 0; i < 6; i++) begin
				for (int m = 0; m < 4; m++) begin
					op = 8'(16 * b + i);
					step(3'h1, {16'h0000, op}, {16'h0000, 8'(64 * m + 42)}, 3'h0, 15'h0000);
					rg = {9'h000, i > 3 || op[1], i > 3 ? 3'h0 : 3'h5, 3'h2};
					chk("alu", cls(0), (i > 3 || m == 3) ? 16'h0001 : 16'h0104);
					chk("regs", {9'h000, o_dest[0], o_mid[2:0], o_low[2:0]}, rg);
				end
			end
		end
	endtask
	task automatic t_grp();
		logic [7:0]  ops [3] = '{8'h80, 8'h81, 8'h83};
		logic [7:0]  mrs [5] = '{8'hC1, 8'h41, 8'hD1, 8'h91, 8'hD9};
		logic [15:0] want [5] = '{16'h0001, 16'h0104, 16'h0001, 16'h0104, 16'h0200};
		for (int j = 0; j < 3; j++) begin
			for (int k = 0; k < 5; k++) begin
				step(3'h1, {16'h0000, ops[j]}, {16'h0000, mrs[k]}, 3'h0, 15'h0000);
				chk("group", cls(0), want[k]);
			end
		end
	endtask
	task automatic t_misc();
		step(3'h1, 24'h00_00C1, 24'h00_00E3, 3'h0, 15'h0000);
		chk("shift imm", cls(0), 16'h0001);
		step(3'h1, 24'h00_00D3, 24'h00_00E3, 3'h1, 15'h0000);
		chk("shift cl", cls(0), 16'h0001);
		step(3'h1, 24'h00_0069, 24'h00_00C0, 3'h1, 15'h0000);
		chk("mul", {o_lat[7:0], o_hi[7:0]}, 16'h0304);
		step(3'h1, 24'h00_00D1, 24'h00_0046, 3'h0, 15'h0000);
		chk("shift mem", cls(0), 16'h0104);
		step(3'h1, 24'h00_006B, 24'h00_0080, 3'h1, 15'h0000);
		chk("mul mem", {o_lat[7:0], o_hi[7:0]}, 16'h0607);
		step(3'h1, 24'h00_008D, 24'h00_0000, 3'h0, 15'h0000);
		chk("lea16", cls(0), 16'h0103);
		step(3'h1, 24'h00_008D, 24'h00_0000, 3'h1, 15'h0000);
		chk("lea32", cls(0), 16'h0102);
		step(3'h1, 24'h00_0053, 24'h00_00FF, 3'h1, 15'h0000);
		chk("push", {o_lat[7:0], o_splat[7:0]}, 16'h0302);
		chk("push reg", {12'h000, o_sp[0], o_mid[2:0]}, 16'h000B);
		step(3'h1, 24'h00_0075, 24'h00_0000, 3'h0, 15'h0000);
		chk("branch", cls(0), 16'h0001);
	endtask
	task automatic t_enter();
		logic [7:0] lat;
		for (int n = 0; n < 6; n++) begin
			lat = (n == 0) ? 8'h0D : (n == 1) ? 8'h11 : 8'(20 + 3 * n);
			step(3'h1, 24'h00_00C8, 24'h00_0000, 3'h1, 15'(n));
			chk("enter", {o_micro[0], o_sp[0], 6'h00, o_lat[7:0]}, {2'h3, 6'h00, lat});
			chk("enter sp", {o_lat[7:0], o_splat[7:0]}, {lat, lat - 8'h01});
		end
	endtask
	// three slots every cycle, back to back, mixed paths
	task automatic t_three();
		step(3'h7, 24'h90_9090, 24'h00_0000, 3'h0, 15'h0000);
		chk("nops", {7'h00, o_valid, o_nop, o_exec}, 16'h01F8);
		xdlc_fetch_model_inst.send(3'h7, 24'hD4_1411, 24'h91_00C3, 3'h0, 15'h0000);
		xdlc_fetch_model_inst.send(3'h7, 24'h80_0037, 24'h91_0000, 3'h0, 15'h0000);
		#1;
		chk("a0", cls(0), 16'h0001);
		chk("a1", cls(1), 16'h0001);
		chk("a2", cls(2), 16'h0410);
		@(posedge clk);
		#1;
		chk("b0", cls(0), 16'h0406);
		chk("b1", cls(1), 16'h0104);
		chk("b2", cls(2), 16'h0104);
	endtask
	task automatic t_unclass();
		step(3'h2, 24'h00_F400, 24'h00_0000, 3'h0, 15'h0000);
		chk("unclass", {o_latv[1], o_unc[1], o_micro[1], 5'h00, o_lat[15:8]}, 16'h4000);
		chk("unclass use", {15'h0000, o_exec[1]}, 16'h0000);
		step(3'h0, 24'h00_0037, 24'h00_0000, 3'h0, 15'h0000);
		chk("empty", {7'h00, o_valid, o_unc, o_micro}, 16'h0000);
	endtask
	// reset in mid-run clears a live result
	task automatic t_reset();
		step(3'h1, 24'h00_0010, 24'h00_0048, 3'h0, 15'h0000);
		chk("before", cls(0), 16'h0104);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		#1;
		chk("reset", {o_valid, o_micro, o_lat[9:0]}, 16'h0000);
		@(posedge clk);
		rst <= 1'b0;
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		failures = 0;
		n_tests = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_ascii();
		t_alu();
		t_grp();
		t_misc();
		t_enter();
		t_three();
		t_unclass();
		t_reset();
		t_ascii();
		print_verdict();
	end
endmodule

// [xdlc_defs.vh]
`ifndef XDLC_DEFS_VH
`define XDLC_DEFS_VH

// ----------------------------------------
// widths
// ----------------------------------------
`define XDLC_BYTE_W        8
`define XDLC_SLOTS         3
`define XDLC_REG_W         3
`define XDLC_LAT_W         8
`define XDLC_NEST_W        5
`define XDLC_CLS_W         4

// ----------------------------------------
// modrm field positions
// ----------------------------------------
`define XDLC_MOD_HI        7
`define XDLC_MOD_LO        6
`define XDLC_MID_HI        5
`define XDLC_MID_LO        3
`define XDLC_LOW_HI        2
`define XDLC_LOW_LO        0
`define XDLC_MOD_REGFORM   2'b11
`define XDLC_OPC_DIR_BIT   1
`define XDLC_REG_ACC       3'h0

// ----------------------------------------
// opcodes and opcode prefixes
// ----------------------------------------
`define XDLC_OP_AAA        8'h37
`define XDLC_OP_AAD        8'hD5
`define XDLC_OP_AAM        8'hD4
`define XDLC_OP_AAS        8'h3F
`define XDLC_OP_GRP1_B     8'h80
`define XDLC_OP_GRP1_V     8'h81
`define XDLC_OP_GRP1_SX    8'h83
`define XDLC_OP_IMUL_V     8'h69
`define XDLC_OP_IMUL_B     8'h6B
`define XDLC_OP_LEA        8'h8D
`define XDLC_OP_NOP        8'h90
`define XDLC_OP_ENTER      8'hC8
`define XDLC_PFX_ADD_RM    6'h00
`define XDLC_PFX_ADC_RM    6'h04
`define XDLC_PFX_SHIFT_D   6'h34
`define XDLC_PFX_ADD_ACC   7'h02
`define XDLC_PFX_ADC_ACC   7'h0A
`define XDLC_PFX_SHIFT_C   7'h60
`define XDLC_PFX_PUSH      5'h0A
`define XDLC_PFX_JCC       4'h7
`define XDLC_MID_ADD       3'h0
`define XDLC_MID_ADC       3'h2

// ----------------------------------------
// instruction classes
// ----------------------------------------
`define XDLC_CL_UNK        4'h0
`define XDLC_CL_ASCII      4'h1
`define XDLC_CL_AAM        4'h2
`define XDLC_CL_ALU_RM     4'h3
`define XDLC_CL_ALU_ACC    4'h4
`define XDLC_CL_GRP1       4'h5
`define XDLC_CL_SHIFT      4'h6
`define XDLC_CL_MUL        4'h7
`define XDLC_CL_LEA        4'h8
`define XDLC_CL_PUSH       4'h9
`define XDLC_CL_ENTER      4'hA
`define XDLC_CL_NOP        4'hB
`define XDLC_CL_JCC        4'hC

// ----------------------------------------
// latencies in clocks
// ----------------------------------------
`define XDLC_LAT_NONE      8'h00
`define XDLC_LAT_ONE       8'h01
`define XDLC_LAT_ASCII     8'h06
`define XDLC_LAT_AAM       8'h10
`define XDLC_LAT_ALU_REG   8'h01
`define XDLC_LAT_ALU_MEM   8'h04
`define XDLC_LAT_ACC       8'h01
`define XDLC_LAT_LOAD      8'h03
`define XDLC_LAT_SHIFT     8'h01
`define XDLC_LAT_MUL_LO    8'h03
`define XDLC_LAT_MUL_HI    8'h04
`define XDLC_LAT_LEA16     8'h03
`define XDLC_LAT_LEA32     8'h02
`define XDLC_LAT_PUSH      8'h03
`define XDLC_LAT_ENTER0    8'h0D
`define XDLC_LAT_ENTER1    8'h11
`define XDLC_LAT_ENT_BASE  8'h14
`define XDLC_LAT_ENT_STEP  8'h03
`define XDLC_LAT_JCC       8'h01
`define XDLC_LAT_NOP       8'h00
`define XDLC_NEST_ZERO     5'h00
`define XDLC_NEST_ONE      5'h01

`endif

// [xdlc_enter_lat.v]
`timescale 1ns/100ps
`include "xdlc_defs.vh"

module xdlc_enter_lat (
	input  wire [4:0] nest,
	output reg  [7:0] latency
);

	// ----------------------------------------
	// frame entry latency by nesting level
	// ----------------------------------------
	// levels 0 and 1 are tabled, deeper levels follow the linear rule
	always @* begin
		if (nest == `XDLC_NEST_ZERO) begin
			latency = `XDLC_LAT_ENTER0;
		end else if (nest == `XDLC_NEST_ONE) begin
			latency = `XDLC_LAT_ENTER1;
		end else begin
			latency = `XDLC_LAT_ENT_BASE + ({3'h0, nest} * `XDLC_LAT_ENT_STEP);
		end
	end

endmodule

// [xdlc_fetch_model.sv]
`timescale 1ns/100ps
// ----
// fetch-side model: hands up to three slots to the decoder each clock
// ----
module xdlc_fetch_model (
	input  wire         clk,
	output logic [2:0]  valid,
	output logic [23:0] opcode,
	output logic [23:0] modrm,
	output logic [2:0]  size32,
	output logic [14:0] nest
);
	// quiet start, nothing presented
	initial begin
		valid = 3'h0;
		opcode = 24'h00_0000;
		modrm = 24'h00_0000;
		size32 = 3'h0;
		nest = 15'h0000;
	end
	// all fields change together just after an edge
	task automatic send(input logic [2:0] v, input logic [23:0] op, input logic [23:0] mr,
		input logic [2:0] sz, input logic [14:0] n);
		@(posedge clk);
		valid <= v;
		opcode <= op;
		modrm <= mr;
		size32 <= sz;
		nest <= n;
	endtask
endmodule

// [xdlc_modrm_split.v]
`timescale 1ns/100ps
`include "xdlc_defs.vh"

module xdlc_modrm_split (
	input  wire [7:0] modrm,
	input  wire [7:0] opcode,
	input  wire       uses_modrm,
	input  wire       fix_acc,
	input  wire       fix_opc,
	output reg  [2:0] mid_reg,
	output reg  [2:0] low_reg,
	output reg        mem_form
);

	// ----------------------------------------
	// field extraction
	// ----------------------------------------
	// opcode-fixed registers override the middle field
	always @* begin
		if (fix_acc) begin
			mid_reg = `XDLC_REG_ACC;
		end else if (fix_opc) begin
			mid_reg = opcode[`XDLC_LOW_HI:`XDLC_LOW_LO];
		end else begin
			mid_reg = modrm[`XDLC_MID_HI:`XDLC_MID_LO];
		end
		low_reg = modrm[`XDLC_LOW_HI:`XDLC_LOW_LO];
		// only 11b is register form; no modrm means no memory access
		mem_form = uses_modrm &&
			(modrm[`XDLC_MOD_HI:`XDLC_MOD_LO] != `XDLC_MOD_REGFORM);
	end

endmodule

// [xdlc_top.v]
`timescale 1ns/100ps
`include "xdlc_defs.vh"

module xdlc_top (
	input  wire        CLK,
	input  wire        RST,
	input  wire [2:0]  IN_VALID,
	input  wire [23:0] IN_OPCODE,
	input  wire [23:0] IN_MODRM,
	input  wire [2:0]  IN_OPSIZE32,
	input  wire [14:0] IN_NEST,
	output reg  [2:0]  OUT_VALID,
	output reg  [2:0]  OUT_UNCLASS,
	output reg  [2:0]  OUT_MICRO,
	output reg  [2:0]  OUT_LAT_VALID,
	output reg  [23:0] OUT_LATENCY,
	output reg  [23:0] OUT_HI_LATENCY,
	output reg  [2:0]  OUT_SP_UPDATE,
	output reg  [23:0] OUT_SP_LATENCY,
	output reg  [2:0]  OUT_MEM_FORM,
	output reg  [8:0]  OUT_MID_REG,
	output reg  [8:0]  OUT_LOW_REG,
	output reg  [2:0]  OUT_DEST_MID,
	output reg  [2:0]  OUT_NOP,
	output reg  [2:0]  OUT_EXEC_USE
);

	// ----------------------------------------
	// opcode classification
	// ----------------------------------------
	// shared by all three slots, so one copy of the decode table
	function [3:0] classify;
		input [7:0] opc;
		input [2:0] mid;
		begin
			if (opc == `XDLC_OP_AAA || opc == `XDLC_OP_AAD || opc == `XDLC_OP_AAS) begin
				classify = `XDLC_CL_ASCII;
			end else if (opc == `XDLC_OP_AAM) begin
				classify = `XDLC_CL_AAM;
			end else if (opc[7:2] == `XDLC_PFX_ADD_RM || opc[7:2] == `XDLC_PFX_ADC_RM) begin
				classify = `XDLC_CL_ALU_RM;
			end else if (opc[7:1] == `XDLC_PFX_ADD_ACC || opc[7:1] == `XDLC_PFX_ADC_ACC) begin
				classify = `XDLC_CL_ALU_ACC;
			end else if ((opc == `XDLC_OP_GRP1_B || opc == `XDLC_OP_GRP1_V ||
				opc == `XDLC_OP_GRP1_SX) &&
				(mid == `XDLC_MID_ADD || mid == `XDLC_MID_ADC)) begin
				classify = `XDLC_CL_GRP1;
			end else if (opc[7:1] == `XDLC_PFX_SHIFT_C || opc[7:2] == `XDLC_PFX_SHIFT_D) begin
				classify = `XDLC_CL_SHIFT;
			end else if (opc == `XDLC_OP_IMUL_V || opc == `XDLC_OP_IMUL_B) begin
				classify = `XDLC_CL_MUL;
			end else if (opc == `XDLC_OP_LEA) begin
				classify = `XDLC_CL_LEA;
			end else if (opc[7:3] == `XDLC_PFX_PUSH) begin
				classify = `XDLC_CL_PUSH;
			end else if (opc == `XDLC_OP_ENTER) begin
				classify = `XDLC_CL_ENTER;
			end else if (opc == `XDLC_OP_NOP) begin
				classify = `XDLC_CL_NOP;
			end else if (opc[7:4] == `XDLC_PFX_JCC) begin
				classify = `XDLC_CL_JCC;
			end else begin
				classify = `XDLC_CL_UNK;
			end
		end
	endfunction

	// ----------------------------------------
	// next values for all slots
	// ----------------------------------------
	// packed like the ports, slot 0 in the low bits
	wire [2:0]  next_unclass;
	wire [2:0]  next_micro;
	wire [2:0]  next_lat_valid;
	wire [23:0] next_latency;
	wire [23:0] next_hi_latency;
	wire [2:0]  next_sp_update;
	wire [23:0] next_sp_latency;
	wire [2:0]  next_mem_form;
	wire [8:0]  next_mid_reg;
	wire [8:0]  next_low_reg;
	wire [2:0]  next_dest_mid;
	wire [2:0]  next_nop;
	wire [2:0]  next_exec_use;

	// slot index for the decoder loop
	genvar g;

	// ----------------------------------------
	// per-slot decoders
	// ----------------------------------------
	// no slot depends on another, so all three finish in one clock
	generate
		for (g = 0; g < `XDLC_SLOTS; g = g + 1) begin : slot
			// this slot's share of the packed inputs
			wire [7:0] opc = IN_OPCODE[g*`XDLC_BYTE_W +: `XDLC_BYTE_W];
			wire [7:0] mrm = IN_MODRM[g*`XDLC_BYTE_W +: `XDLC_BYTE_W];
			wire [4:0] nst = IN_NEST[g*`XDLC_NEST_W +: `XDLC_NEST_W];
			wire       sz32 = IN_OPSIZE32[g];
			// one class per slot, picks path and latency
			wire [3:0] cls = classify(opc, mrm[`XDLC_MID_HI:`XDLC_MID_LO]);
			// decode results, settled within the cycle
			wire       uses_mrm;
			wire [2:0] mid_r;
			wire [2:0] low_r;
			wire       mem;
			wire [7:0] ent_lat;
			reg        micro;
			reg        lat_ok;
			reg  [7:0] lat;
			reg  [7:0] hi_lat;
			reg        sp_up;
			reg        dst_mid;
			reg        is_nop;

			// modrm is only present for register/memory operand forms
			assign uses_mrm = (cls == `XDLC_CL_ALU_RM) || (cls == `XDLC_CL_GRP1) ||
				(cls == `XDLC_CL_SHIFT) || (cls == `XDLC_CL_MUL) ||
				(cls == `XDLC_CL_LEA);

			// register numbers and operand form of this slot
			xdlc_modrm_split u_split (
				.modrm      (mrm),
				.opcode     (opc),
				.uses_modrm (uses_mrm),
				.fix_acc    (cls == `XDLC_CL_ALU_ACC),
				.fix_opc    (cls == `XDLC_CL_PUSH),
				.mid_reg    (mid_r),
				.low_reg    (low_r),
				.mem_form   (mem)
			);

			// frame entry cost, read only by the frame entry class
			xdlc_enter_lat u_enter (
				.nest    (nst),
				.latency (ent_lat)
			);

			// path and latency selection per class
			always @* begin
				micro   = 1'b0;
				lat_ok  = 1'b1;
				lat     = `XDLC_LAT_NONE;
				hi_lat  = `XDLC_LAT_NONE;
				sp_up   = 1'b0;
				dst_mid = 1'b0;
				is_nop  = 1'b0;
				case (cls)
					// adjust forms run from microcode
					`XDLC_CL_ASCII: begin
						micro = 1'b1;
						lat   = `XDLC_LAT_ASCII;
					end
					`XDLC_CL_AAM: begin
						micro = 1'b1;
						lat   = `XDLC_LAT_AAM;
					end
					// single-operation arithmetic
					`XDLC_CL_ALU_RM: begin
						// bit 1 set means the middle-field register is written
						dst_mid = opc[`XDLC_OPC_DIR_BIT];
						lat = mem ? `XDLC_LAT_ALU_MEM : `XDLC_LAT_ALU_REG;
					end
					`XDLC_CL_ALU_ACC: begin
						dst_mid = 1'b1;
						lat     = `XDLC_LAT_ACC;
					end
					`XDLC_CL_GRP1: begin
						lat = mem ? `XDLC_LAT_ALU_MEM : `XDLC_LAT_ALU_REG;
					end
					`XDLC_CL_SHIFT: begin
						// count operand is never looked at
						lat = mem ? (`XDLC_LAT_SHIFT + `XDLC_LAT_LOAD)
							: `XDLC_LAT_SHIFT;
					end
					`XDLC_CL_MUL: begin
						dst_mid = 1'b1;
						lat     = mem ? (`XDLC_LAT_MUL_LO + `XDLC_LAT_LOAD)
							: `XDLC_LAT_MUL_LO;
						hi_lat  = mem ? (`XDLC_LAT_MUL_HI + `XDLC_LAT_LOAD)
							: `XDLC_LAT_MUL_HI;
					end
					`XDLC_CL_LEA: begin
						dst_mid = 1'b1;
						// narrow destination needs an extra merge step
						lat = sz32 ? `XDLC_LAT_LEA32 : `XDLC_LAT_LEA16;
					end
					// stores that also move the stack pointer
					`XDLC_CL_PUSH: begin
						sp_up = 1'b1;
						lat   = `XDLC_LAT_PUSH;
					end
					`XDLC_CL_ENTER: begin
						micro = 1'b1;
						sp_up = 1'b1;
						lat   = ent_lat;
					end
					`XDLC_CL_NOP: begin
						is_nop = 1'b1;
						lat    = `XDLC_LAT_NOP;
					end
					`XDLC_CL_JCC: begin
						// mispredict cost is the scheduler's concern
						lat = `XDLC_LAT_JCC;
					end
					default: begin
						lat_ok = 1'b0;
						lat    = `XDLC_LAT_NONE;
					end
				endcase
				// only multiply splits its result; other classes finish at once
				if (cls != `XDLC_CL_MUL) begin
					hi_lat = lat;
				end
			end

			// ----------------------------------------
			// slot results onto the packed next buses
			// ----------------------------------------
			// path and class flags
			assign next_unclass[g]   = (cls == `XDLC_CL_UNK);
			assign next_micro[g]     = micro;
			assign next_lat_valid[g] = lat_ok;

			// latency fields, ungated: the flags say whether to trust them
			assign next_latency[g*`XDLC_LAT_W +: `XDLC_LAT_W]    = lat;
			assign next_hi_latency[g*`XDLC_LAT_W +: `XDLC_LAT_W] = hi_lat;
			assign next_sp_update[g] = sp_up;
			// stack pointer result arrives one clock before the full latency
			assign next_sp_latency[g*`XDLC_LAT_W +: `XDLC_LAT_W] =
				sp_up ? (lat - `XDLC_LAT_ONE) : `XDLC_LAT_NONE;

			// operand form and register numbers
			assign next_mem_form[g]  = mem;
			assign next_mid_reg[g*`XDLC_REG_W +: `XDLC_REG_W] = mid_r;
			assign next_low_reg[g*`XDLC_REG_W +: `XDLC_REG_W] = low_r;

			// destination side and resource use
			assign next_dest_mid[g]  = dst_mid;
			assign next_nop[g]       = is_nop;
			// no-ops and unknowns claim no execution unit
			assign next_exec_use[g]  = lat_ok & ~is_nop;
		end
	endgenerate

	// ----------------------------------------
	// output register
	// ----------------------------------------
	// every flag is gated by its slot valid so a stale flag never looks live; the latency and register fields are not
	always @(posedge CLK) begin
		if (RST) begin
			OUT_VALID      <= 3'h0;
			OUT_UNCLASS    <= 3'h0;
			OUT_MICRO      <= 3'h0;
			OUT_LAT_VALID  <= 3'h0;
			// fields too, so nothing reads unknown after reset
			OUT_LATENCY    <= 24'h00_0000;
			OUT_HI_LATENCY <= 24'h00_0000;
			OUT_SP_UPDATE  <= 3'h0;
			OUT_SP_LATENCY <= 24'h00_0000;
			OUT_MEM_FORM   <= 3'h0;
			OUT_MID_REG    <= 9'h000;
			OUT_LOW_REG    <= 9'h000;
			OUT_DEST_MID   <= 3'h0;
			OUT_NOP        <= 3'h0;
			OUT_EXEC_USE   <= 3'h0;
		end else begin
			OUT_VALID      <= IN_VALID;
			OUT_UNCLASS    <= next_unclass & IN_VALID;
			OUT_MICRO      <= next_micro & IN_VALID;
			OUT_LAT_VALID  <= next_lat_valid & IN_VALID;
			// fields pass ungated; cheaper than gating every bit
			OUT_LATENCY    <= next_latency;
			OUT_HI_LATENCY <= next_hi_latency;
			OUT_SP_UPDATE  <= next_sp_update & IN_VALID;
			OUT_SP_LATENCY <= next_sp_latency;
			OUT_MEM_FORM   <= next_mem_form & IN_VALID;
			OUT_MID_REG    <= next_mid_reg;
			OUT_LOW_REG    <= next_low_reg;
			OUT_DEST_MID   <= next_dest_mid & IN_VALID;
			OUT_NOP        <= next_nop & IN_VALID;
			OUT_EXEC_USE   <= next_exec_use & IN_VALID;
		end
	end

endmodule

// [xdlc_top_monitor.sv]
`timescale 1ns/100ps
// ----
// decode checker: slot 0 classes and slot-parallel relations
// ----
module xdlc_top_monitor (
	input wire        CLK,
	input wire        RST,
	input wire [2:0]  IN_VALID,
	input wire [23:0] IN_OPCODE,
	input wire [23:0] IN_MODRM,
	input wire [2:0]  OUT_VALID,
	input wire [2:0]  OUT_UNCLASS,
	input wire [2:0]  OUT_MICRO,
	input wire [2:0]  OUT_LAT_VALID,
	input wire [23:0] OUT_LATENCY,
	input wire [2:0]  OUT_MEM_FORM,
	input wire [8:0]  OUT_MID_REG,
	input wire [8:0]  OUT_LOW_REG,
	input wire [2:0]  OUT_DEST_MID
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	// reset sits in each input-sampling antecedent (not p_unclass): a sync reset released at an edge is still seen by the design
	sequence s_live;
		!RST;
	endsequence
	sequence s_alu_rm;
		!RST && IN_VALID[0] && IN_OPCODE[7:5] == 3'h0 && IN_OPCODE[3:2] == 2'h0;
	endsequence
	sequence s_ascii;
		!RST && IN_VALID[0] && (IN_OPCODE[7:0] == 8'h37 || IN_OPCODE[7:0] == 8'hD5
			|| IN_OPCODE[7:0] == 8'h3F);
	endsequence
	sequence s_acc;
		!RST && IN_VALID[0] && IN_OPCODE[7:1] == 7'h0A;
	endsequence
	sequence s_grp_adc;
		!RST && IN_VALID[0] && IN_OPCODE[7:1] == 7'h40 && IN_MODRM[5:3] == 3'h2;
	endsequence
	property p_mid_field;
		s_alu_rm |=> OUT_MID_REG[2:0] == $past(IN_MODRM[5:3]);
	endproperty
	a_mid_field: assert property (p_mid_field) else $error("mid register wrong");
	property p_low_field;
		s_live |=> OUT_LOW_REG[2:0] == $past(IN_MODRM[2:0]) && OUT_LOW_REG[8:6] == $past(IN_MODRM[18:16]);
	endproperty
	a_low_field: assert property (p_low_field) else $error("low register wrong");
	property p_mem_form;
		s_alu_rm |=> OUT_MEM_FORM[0] == ($past(IN_MODRM[7:6]) != 2'h3);
	endproperty
	a_mem_form: assert property (p_mem_form) else $error("memory form wrong");
	property p_ascii;
		s_ascii |=> OUT_MICRO[0] && OUT_LATENCY[7:0] == 8'h06;
	endproperty
	a_ascii: assert property (p_ascii) else $error("ascii adjust wrong");
	property p_mul_adjust;
		!RST && IN_VALID[0] && IN_OPCODE[7:0] == 8'hD4 |=> OUT_MICRO[0] && OUT_LATENCY[7:0] == 8'h10;
	endproperty
	a_mul_adjust: assert property (p_mul_adjust) else $error("multiply adjust wrong");
	property p_alu_rm;
		s_alu_rm |=> !OUT_MICRO[0] && OUT_DEST_MID[0] == $past(IN_OPCODE[1])
			&& OUT_LATENCY[7:0] == ($past(IN_MODRM[7:6]) == 2'h3 ? 8'h01 : 8'h04);
	endproperty
	a_alu_rm: assert property (p_alu_rm) else $error("alu form wrong");
	property p_acc;
		s_acc |=> !OUT_MICRO[0] && OUT_LATENCY[7:0] == 8'h01 && OUT_MID_REG[2:0] == 3'h0;
	endproperty
	a_acc: assert property (p_acc) else $error("accumulator form wrong");
	property p_grp_adc;
		s_grp_adc |=> !OUT_UNCLASS[0] && !OUT_MICRO[0]
			&& OUT_LATENCY[7:0] == ($past(IN_MODRM[7:6]) == 2'h3 ? 8'h01 : 8'h04);
	endproperty
	a_grp_adc: assert property (p_grp_adc) else $error("group carry add wrong");
	property p_three;
		!RST && IN_VALID == 3'h7 |=> OUT_VALID == 3'h7;
	endproperty
	a_three: assert property (p_three) else $error("three slots not decoded");
	property p_unclass;
		OUT_UNCLASS[0] |-> !OUT_LAT_VALID[0] && OUT_LATENCY[7:0] == 8'h00;
	endproperty
	a_unclass: assert property (p_unclass) else $error("unclassified has latency");
endmodule

bind xdlc_top xdlc_top_monitor xdlc_top_monitor_inst (
	.CLK(CLK), .RST(RST), .IN_VALID(IN_VALID), .IN_OPCODE(IN_OPCODE), .IN_MODRM(IN_MODRM),
	.OUT_VALID(OUT_VALID), .OUT_UNCLASS(OUT_UNCLASS), .OUT_MICRO(OUT_MICRO),
	.OUT_LAT_VALID(OUT_LAT_VALID), .OUT_LATENCY(OUT_LATENCY), .OUT_MEM_FORM(OUT_MEM_FORM),
	.OUT_MID_REG(OUT_MID_REG), .OUT_LOW_REG(OUT_LOW_REG), .OUT_DEST_MID(OUT_DEST_MID)
);
